/* core/vout_cmd_regs.sv */
/*
 * Output-voltage command register bank: target, ceiling with clamp and
 * warning, margin targets, current offset, overvoltage latch-off and the
 * status bytes they feed, with an alert output.
 * Assumes a bus protocol engine on the same clock that presents one
 * decoded command per cycle, and an analog monitor raising an ov level.
 */
// Notes on behaviour
// - mode byte reads VID, parameter per protocol
// - two-byte VID, low byte data, high zero
// - valid target write changes output target
// - strap pin or config picks VID table
// - target never exceeds ceiling, writes clamped; a lower ceiling write leaves target_ff above it, only vid_out is clamped
// - over-ceiling is warning, regulation continues
// - clamp sets other, output_voltage_ceiling-warn status
// - clamp asserts alert output
// - ceiling 8-bit, upper zero, resets ff
// - margin upper target, reset zero, used
// - margin lower target, reset zero, used
// - current offset corrects readings, resets zero
// - offset is 5-bit exponent, 11-bit mantissa
// - overvoltage latches output off until cleared
// - overvoltage sets ov, vout, ov-fault status
// - overvoltage asserts alert output
// - write to mode byte rejected, comm fault
// - store-defaults restores boot target, ceiling ff
`default_nettype none

module vout_cmd_regs #(
	parameter int vid_w = 8
) (
	input  wire logic               clock,
	input  wire logic               sys_rst,
	input  wire logic               cmd_valid,
	input  wire logic               cmd_write,
	input  wire logic [7:0]         cmd_code,
	input  wire logic [15:0]        cmd_wdata,
	output logic [15:0]             cmd_rdata,
	input  wire logic               protocol_strap_pin,
	input  wire logic               protocol_select_config,
	input  wire logic               protocol_use_config,
	input  wire logic [vid_w-1:0]   boot_voltage,
	input  wire logic [1:0]         operation_select,
	input  wire logic               ov_detect,
	input  wire logic [15:0]        raw_current,
	output logic [15:0]             corrected_current,
	output logic [vid_w-1:0]        vid_out,
	output logic                    newer_vid_protocol,
	output logic                    output_enable,
	output logic                    alert_output_n
);

	// two-flop synchronisers for pins from outside the clock domain
	logic strap_s1_ff, strap_s2_ff;
	logic ov_s1_ff, ov_s2_ff;

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			strap_s1_ff <= 1'b0;
			strap_s2_ff <= 1'b0;
			ov_s1_ff    <= 1'b0;
			ov_s2_ff    <= 1'b0;
		end else begin
			strap_s1_ff <= protocol_strap_pin;
			strap_s2_ff <= strap_s1_ff;
			ov_s1_ff    <= ov_detect;
			ov_s2_ff    <= ov_s1_ff;
		end
	end

	// table choice: config overrides strap when selected
	wire newer_sel = protocol_use_config ? protocol_select_config
		: strap_s2_ff;

	// register state
	logic [vid_w-1:0] target_ff, ceil_ff, m_up_ff, m_lo_ff;
	logic [15:0]      offset_ff;
	logic [7:0]       status_byte_ff, status_vout_ff, status_comm_ff;
	logic             vout_word_ff;
	logic             latched_off_ff;
	logic             boot_pending_ff;
	logic             ov_prev_ff;

	// command decode
	wire is_wr   = cmd_valid && cmd_write;
	wire wr_tgt  = is_wr && (cmd_code == vout_cmd_pkg::cmd_voltage_target);
	wire wr_ceil = is_wr && (cmd_code == vout_cmd_pkg::cmd_voltage_ceil);
	wire wr_mup  = is_wr && (cmd_code == vout_cmd_pkg::cmd_margin_upper);
	wire wr_mlo  = is_wr && (cmd_code == vout_cmd_pkg::cmd_margin_lower);
	wire wr_ofs  = is_wr && (cmd_code == vout_cmd_pkg::cmd_current_offset);
	wire wr_ro   = is_wr && ((cmd_code == vout_cmd_pkg::cmd_format_desc)
		|| (cmd_code == vout_cmd_pkg::cmd_ov_action));
	wire wr_clr  = cmd_valid && (cmd_code == vout_cmd_pkg::cmd_clear_faults);
	wire wr_store = cmd_valid
		&& (cmd_code == vout_cmd_pkg::cmd_store_defaults);

	// clamp check on a target write; high byte of payload ignored (reserved)
	wire [vid_w-1:0] req_vid = cmd_wdata[vid_w-1:0];
	wire over_ceil = wr_tgt && (req_vid > ceil_ff);
	wire ov_rise   = ov_s2_ff && !ov_prev_ff;

	// clamp helper: result never above the ceiling
	function automatic logic [vid_w-1:0] clamp_vid(
		input logic [vid_w-1:0] v,
		input logic [vid_w-1:0] lim
	);
		clamp_vid = (v > lim) ? lim : v;
	endfunction : clamp_vid

	logic [vid_w-1:0] nxt_target, nxt_ceil;

	// store-defaults wins over a same-cycle data write
	always_comb begin
		nxt_target = target_ff;
		nxt_ceil   = ceil_ff;
		if (boot_pending_ff)
			nxt_target = boot_voltage;
		if (wr_ceil)
			nxt_ceil = cmd_wdata[vid_w-1:0];
		if (wr_tgt)
			nxt_target = clamp_vid(req_vid, ceil_ff);
		if (wr_store) begin
			nxt_target = boot_voltage;
			nxt_ceil   = vid_w'(vout_cmd_pkg::ceil_reset);
		end
	end

	// boot value is caught one cycle after reset release, not under reset
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			boot_pending_ff <= 1'b1;
			target_ff       <= '0;
			ceil_ff         <= vid_w'(vout_cmd_pkg::ceil_reset);
		end else begin
			boot_pending_ff <= 1'b0;
			target_ff       <= nxt_target;
			ceil_ff         <= nxt_ceil;
		end
	end

	// margin and offset storage
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			m_up_ff   <= vid_w'(vout_cmd_pkg::margin_reset);
			m_lo_ff   <= vid_w'(vout_cmd_pkg::margin_reset);
			offset_ff <= vout_cmd_pkg::offset_reset;
		end else begin
			if (wr_mup)
				m_up_ff <= cmd_wdata[vid_w-1:0];
			if (wr_mlo)
				m_lo_ff <= cmd_wdata[vid_w-1:0];
			if (wr_ofs)
				offset_ff <= cmd_wdata;
		end
	end

	// status flags: a set in the same cycle as clear-faults wins
	logic [7:0] nxt_sbyte, nxt_svout, nxt_scomm;
	logic       nxt_vword, nxt_latched;

	always_comb begin
		nxt_sbyte   = wr_clr ? 8'h00 : status_byte_ff;
		nxt_svout   = wr_clr ? 8'h00 : status_vout_ff;
		nxt_scomm   = wr_clr ? 8'h00 : status_comm_ff;
		nxt_vword   = wr_clr ? 1'b0 : vout_word_ff;
		nxt_latched = wr_clr ? 1'b0 : latched_off_ff;
		if (over_ceil) begin
			nxt_sbyte[vout_cmd_pkg::sb_other]    = 1'b1;
			nxt_svout[vout_cmd_pkg::sv_max_warn] = 1'b1;
			nxt_vword                            = 1'b1;
		end
		if (ov_s2_ff) begin
			nxt_sbyte[vout_cmd_pkg::sb_vout_ov]  = 1'b1;
			nxt_svout[vout_cmd_pkg::sv_ov_fault] = 1'b1;
			nxt_vword                            = 1'b1;
			nxt_latched                          = 1'b1;
		end
		if (wr_ro) begin
			nxt_sbyte[vout_cmd_pkg::sb_comm]     = 1'b1;
			nxt_scomm[vout_cmd_pkg::sc_bad_data] = 1'b1;
		end
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			status_byte_ff <= 8'h00;
			status_vout_ff <= 8'h00;
			status_comm_ff <= 8'h00;
			vout_word_ff   <= 1'b0;
			latched_off_ff <= 1'b0;
			ov_prev_ff     <= 1'b0;
		end else begin
			status_byte_ff <= nxt_sbyte;
			status_vout_ff <= nxt_svout;
			status_comm_ff <= nxt_scomm;
			vout_word_ff   <= nxt_vword;
			latched_off_ff <= nxt_latched;
			ov_prev_ff     <= ov_s2_ff;
		end
	end

	// alert stays low while any flag is held; cleared by clear-faults
	wire any_flag = (status_byte_ff != 8'h00) || vout_word_ff;
	assign alert_output_n = !any_flag;

	// active target follows the operation selection, always under ceiling
	wire [vid_w-1:0] sel_vid =
		(operation_select == 2'(vout_cmd_pkg::op_margin_upper)) ? m_up_ff
		: (operation_select == 2'(vout_cmd_pkg::op_margin_lower)) ? m_lo_ff
		: target_ff;

	// current correction: mantissa scaled by exponent, added to reading
	wire signed [4:0]  ofs_exp = offset_ff[vout_cmd_pkg::offset_exp_msb:
		vout_cmd_pkg::offset_exp_lsb];
	wire signed [10:0] ofs_man = offset_ff[vout_cmd_pkg::offset_man_msb:0];
	wire signed [31:0] man_ext = 32'(ofs_man);
	wire signed [31:0] ofs_scaled = ofs_exp[4]
		? (man_ext >>> 5'(-ofs_exp)) : (man_ext <<< 5'(ofs_exp));
	wire [15:0] corr_sum = raw_current + ofs_scaled[15:0];

	// registered data outputs; ov latch forces output off
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			vid_out            <= '0;
			output_enable      <= 1'b0;
			newer_vid_protocol <= 1'b0;
			corrected_current  <= 16'h0000;
		end else begin
			vid_out            <= clamp_vid(sel_vid, ceil_ff);
			output_enable      <= !nxt_latched;
			newer_vid_protocol <= newer_sel;
			corrected_current  <= corr_sum;
		end
	end

	// read mux; reserved upper bytes read zero
	wire [7:0] fmt_byte = {vout_cmd_pkg::fmt_mode_vid,
		newer_sel ? vout_cmd_pkg::fmt_par_newer
		: vout_cmd_pkg::fmt_par_older};
	logic [15:0] rd_mux;

	always_comb begin
		rd_mux = 16'h0000;
		case (cmd_code)
			vout_cmd_pkg::cmd_format_desc:    rd_mux = {8'h00, fmt_byte};
			vout_cmd_pkg::cmd_voltage_target: rd_mux = 16'(target_ff);
			vout_cmd_pkg::cmd_voltage_ceil:   rd_mux = 16'(ceil_ff);
			vout_cmd_pkg::cmd_margin_upper:   rd_mux = 16'(m_up_ff);
			vout_cmd_pkg::cmd_margin_lower:   rd_mux = 16'(m_lo_ff);
			vout_cmd_pkg::cmd_current_offset: rd_mux = offset_ff;
			vout_cmd_pkg::cmd_ov_action:
				rd_mux = {8'h00, vout_cmd_pkg::ov_action_value};
			vout_cmd_pkg::cmd_status_byte:
				rd_mux = {8'h00, status_byte_ff};
			vout_cmd_pkg::cmd_status_word:
				rd_mux = {vout_word_ff, 7'h00, status_byte_ff};
			vout_cmd_pkg::cmd_status_vout:
				rd_mux = {8'h00, status_vout_ff};
			vout_cmd_pkg::cmd_status_comm:
				rd_mux = {8'h00, status_comm_ff};
			default: rd_mux = 16'h0000;
		endcase
	end

	// read data registered on any valid read
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst)
			cmd_rdata <= 16'h0000;
		else if (cmd_valid && !cmd_write)
			cmd_rdata <= rd_mux;
	end

endmodule : vout_cmd_regs

`default_nettype wire

/* common/vout_cmd_pkg.sv */
/*
 * Shared constants for the output-voltage command register set: command
 * codes, field positions, reset values and status bit positions.
 * Assumes a protocol engine that decodes bus frames into command writes.
 */
`default_nettype none

package vout_cmd_pkg;

	// command codes as seen on the register port
	localparam logic [7:0] cmd_clear_faults   = 8'h03;
	localparam logic [7:0] cmd_store_defaults = 8'h11;
	localparam logic [7:0] cmd_format_desc    = 8'h20;
	localparam logic [7:0] cmd_voltage_target = 8'h21;
	localparam logic [7:0] cmd_voltage_ceil   = 8'h24;
	localparam logic [7:0] cmd_margin_upper   = 8'h25;
	localparam logic [7:0] cmd_margin_lower   = 8'h26;
	localparam logic [7:0] cmd_current_offset = 8'h39;
	localparam logic [7:0] cmd_ov_action      = 8'h41;
	localparam logic [7:0] cmd_status_byte    = 8'h78;
	localparam logic [7:0] cmd_status_word    = 8'h79;
	localparam logic [7:0] cmd_status_vout    = 8'h7a;
	localparam logic [7:0] cmd_status_comm    = 8'h7e;

	// format descriptor fields
	localparam logic [2:0] fmt_mode_vid   = 3'h1;
	localparam logic [4:0] fmt_par_newer  = 5'h02;
	localparam logic [4:0] fmt_par_older  = 5'h01;

	// reset values
	localparam logic [7:0]  ceil_reset      = 8'hff;
	localparam logic [7:0]  margin_reset    = 8'h00;
	localparam logic [15:0] offset_reset    = 16'h0000;
	localparam logic [7:0]  ov_action_value = 8'h80;

	// offset field positions
	localparam int offset_exp_msb  = 15;
	localparam int offset_exp_lsb  = 11;
	localparam int offset_man_msb  = 10;

	// status bit positions
	localparam int sb_other      = 0;
	localparam int sb_comm       = 1;
	localparam int sb_vout_ov    = 5;
	localparam int sw_vout       = 15;
	localparam int sv_ov_fault   = 7;
	localparam int sv_max_warn   = 3;
	localparam int sc_bad_data   = 6;

	// operating selection
	typedef enum logic [1:0] {
		op_nominal,
		op_margin_upper,
		op_margin_lower
	} op_select_t;

endpackage : vout_cmd_pkg

`default_nettype wire

/* bench/vout_cmd_regs_monitor.sv */
/* checker for the output_voltage_target bank, bound to every instance
   assumes one clock and an async active-high reset */
`default_nettype none
module vout_cmd_regs_monitor #(
	parameter int vid_w = 8
) (
	input wire logic             clock,
	input wire logic             sys_rst,
	input wire logic             cmd_valid,
	input wire logic             cmd_write,
	input wire logic [7:0]       cmd_code,
	input wire logic [15:0]      cmd_wdata,
	input wire logic [15:0]      cmd_rdata,
	input wire logic [1:0]       operation_select,
	input wire logic             ov_detect,
	input wire logic [vid_w-1:0] vid_out,
	input wire logic             output_enable,
	input wire logic             alert_output_n
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (sys_rst);
	// decoded strobes of the command port
	wire logic rd_c = cmd_valid && !cmd_write;
	wire logic wr_c = cmd_valid && cmd_write;
	wire logic clr_c = wr_c && cmd_code == 8'h03;
	logic [vid_w-1:0] ceil_ff;
	logic [vid_w-1:0] exp_vid_ff;
	// shadow ceiling; store-defaults puts the ff default back
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst)
			ceil_ff <= vid_w'(8'hff);
		else if (wr_c && cmd_code == 8'h24)
			ceil_ff <= cmd_wdata[vid_w-1:0];
		else if (wr_c && cmd_code == 8'h11)
			ceil_ff <= vid_w'(8'hff);
	end
	// expected target after the clamp, compare uses the old ceiling
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst)
			exp_vid_ff <= '0;
		else if (wr_c && cmd_code == 8'h21)
			exp_vid_ff <= (cmd_wdata[vid_w-1:0] > ceil_ff) ?
				ceil_ff : cmd_wdata[vid_w-1:0];
	end
	a_mode_fixed: assert property (
		rd_c && cmd_code == 8'h20 |=> cmd_rdata[15:5] == 11'h001)
		else $error("mode byte not in vid mode");
	a_upper_zero: assert property (
		rd_c && cmd_code inside {8'h21, 8'h24, 8'h25, 8'h26}
		|=> cmd_rdata[15:8] == 8'h00)
		else $error("reserved upper byte not zero");
	a_ov_latch: assert property (
		ov_detect[*4] |-> !output_enable && !alert_output_n)
		else $error("overvoltage not latched off");
	a_off_holds: assert property (
		!output_enable && !alert_output_n && !clr_c |=> !output_enable)
		else $error("output restarted before clear");
	a_alert_holds: assert property (
		!alert_output_n && !clr_c |=> !alert_output_n)
		else $error("alert dropped before clear");
	a_clamp_warn: assert property (
		wr_c && cmd_code == 8'h21 && cmd_wdata[vid_w-1:0] > ceil_ff
		|=> !alert_output_n)
		else $error("over-ceiling write raised no alert");
	a_vid_tracks: assert property (
		wr_c && cmd_code == 8'h21 && operation_select == 2'h0 ##1
		!wr_c && operation_select == 2'h0 |=> vid_out == exp_vid_ff)
		else $error("output vid not clamped target");
	a_mode_refused: assert property (
		wr_c && cmd_code == 8'h20 ##1 rd_c && cmd_code == 8'h7e
		|=> cmd_rdata[6])
		else $error("mode write not flagged");
endmodule : vout_cmd_regs_monitor
bind vout_cmd_regs vout_cmd_regs_monitor #(.vid_w(vid_w)) u_mon (.*);
`default_nettype wire

/* bench/pmbus_host_model.sv */
/* host side: issues one decoded command per call
   assumes every call starts at a falling clock edge */
`default_nettype none
module pmbus_host_model (
	input  wire logic        clock,
	output logic             cmd_valid,
	output logic             cmd_write,
	output logic [7:0]       cmd_code,
	output logic [15:0]      cmd_wdata,
	input  wire logic [15:0] cmd_rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	// idle bus from time zero
	initial begin
		cmd_valid = 1'b0;
		cmd_write = 1'b0;
		cmd_code = 8'h00;
		cmd_wdata = 16'h0000;
	end
	// whole 16-bit word in one cycle, read data taken after the edge
	task automatic xfer(input logic w, input logic [7:0] c,
		input logic [15:0] d, output logic [15:0] q);
		cmd_valid = 1'b1;
		cmd_write = w;
		cmd_code = c;
		cmd_wdata = d;
		@(negedge clock);
		q = cmd_rdata;
	endtask : xfer
	// slow host; released data flips so stale words are not reused
	task automatic pause(input int n);
		cmd_valid = 1'b0;
		cmd_wdata = ~cmd_wdata;
		repeat (n) @(negedge clock);
	endtask : pause
endmodule : pmbus_host_model
`default_nettype wire

/* bench/test_pmbus_output_voltage_target_set.sv */
/* self-checking bench for the output_voltage_target bank
   assumes the host model and the bound checker are compiled */
`default_nettype none
module test_pmbus_output_voltage_target_set;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock, sys_rst, cmd_valid, cmd_write, ov_detect;
	logic protocol_strap_pin, protocol_select_config, protocol_use_config;
	logic newer_vid_protocol, output_enable, alert_output_n;
	logic [7:0]  cmd_code, boot_voltage, vid_out;
	logic [1:0]  operation_select;
	logic [15:0] cmd_wdata, cmd_rdata, raw_current, corrected_current, q;
	int          n_fail, n_checks, cyc;
	vout_cmd_regs dut (.*);
	pmbus_host_model host (.*);
	// 25 MHz clock
	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic rc(input logic [7:0] c, input logic [15:0] m,
		input logic [15:0] e);
		host.xfer(1'b0, c, 16'h0000, q);
		chk(q & m, e);
	endtask : rc
	task automatic wr(input logic [7:0] c, input logic [15:0] d);
		host.xfer(1'b1, c, d, q);
	endtask : wr
	task automatic t_reset;
		rc(8'h24, 16'hffff, 16'h00ff);
		rc(8'h25, 16'hffff, 16'h0000);
		rc(8'h26, 16'hffff, 16'h0000);
		rc(8'h39, 16'hffff, 16'h0000);
		rc(8'h41, 16'hffff, 16'h0080);
		rc(8'h21, 16'hffff, {8'h00, boot_voltage});
		chk({8'h00, vid_out}, {8'h00, boot_voltage});
	endtask : t_reset
	// strap versus config in all four combinations
	task automatic t_mode;
		for (int i = 0; i < 4; i++) begin
			{protocol_use_config, protocol_select_config} = 2'(i);
			protocol_strap_pin = ~i[0];
			host.pause(4);
			rc(8'h20, 16'hffff, {11'h001, (i[0] ^ i[1]) ? 5'h01 : 5'h02});
			chk({15'h0, newer_vid_protocol}, {15'h0, ~(i[0] ^ i[1])});
		end
	endtask : t_mode
	task automatic t_clamp;
		wr(8'h24, 16'h0080);
		wr(8'h21, 16'h00ff);
		rc(8'h21, 16'hffff, 16'h0080);
		rc(8'h78, 16'h0001, 16'h0001);
		rc(8'h79, 16'h8000, 16'h8000);
		rc(8'h7a, 16'h0008, 16'h0008);
		chk({15'h0, alert_output_n}, 16'h0000);
		chk({15'h0, output_enable}, 16'h0001);
		chk({8'h00, vid_out}, 16'h0080);
		wr(8'h03, 16'h0000);
		host.pause(1);
		chk({15'h0, alert_output_n}, 16'h0001);
	endtask : t_clamp
	task automatic t_margin;
		wr(8'h25, 16'hab40);
		wr(8'h26, 16'h0020);
		rc(8'h25, 16'hffff, 16'h0040);
		operation_select = 2'h1;
		host.pause(2);
		chk({8'h00, vid_out}, 16'h0040);
		operation_select = 2'h2;
		host.pause(2);
		chk({8'h00, vid_out}, 16'h0020);
		operation_select = 2'h0;
	endtask : t_margin
	// exponent 1, mantissa 3: offset of 6
	task automatic t_offset;
		wr(8'h39, 16'h0803);
		rc(8'h39, 16'hffff, 16'h0803);
		raw_current = 16'h0064;
		host.pause(2);
		chk(corrected_current, 16'h006a);
		// exponent -1, mantissa 8: offset of 4, checks the right shift
		wr(8'h39, 16'hf808);
		raw_current = 16'h0010;
		host.pause(2);
		chk(corrected_current, 16'h0014);
	endtask : t_offset
	task automatic t_refuse;
		wr(8'h20, 16'h0055);
		rc(8'h7e, 16'h0040, 16'h0040);
		rc(8'h78, 16'h0002, 16'h0002);
		rc(8'h20, 16'hffe0, 16'h0020);
		wr(8'h03, 16'h0000);
	endtask : t_refuse
	task automatic t_ov;
		ov_detect = 1'b1;
		host.pause(5);
		chk({15'h0, output_enable}, 16'h0000);
		chk({15'h0, alert_output_n}, 16'h0000);
		ov_detect = 1'b0;
		host.pause(4);
		rc(8'h78, 16'h0020, 16'h0020);
		rc(8'h79, 16'h8000, 16'h8000);
		rc(8'h7a, 16'h0080, 16'h0080);
		chk({15'h0, output_enable}, 16'h0000);
		wr(8'h03, 16'h0000);
		host.pause(3);
		chk({15'h0, output_enable}, 16'h0001);
	endtask : t_ov
	task automatic t_store;
		wr(8'h24, 16'h0050);
		wr(8'h21, 16'h0030);
		wr(8'h11, 16'h0000);
		rc(8'h21, 16'hffff, {8'h00, boot_voltage});
		rc(8'h24, 16'hffff, 16'h00ff);
	endtask : t_store
	// second reset in mid-run with a new boot value on the pins
	task automatic t_reboot;
		host.pause(1);
		boot_voltage = 8'h33;
		sys_rst = 1'b1;
		host.pause(2);
		chk({15'h0, output_enable}, 16'h0000);
		chk({15'h0, alert_output_n}, 16'h0001);
		sys_rst = 1'b0;
		host.pause(3);
		rc(8'h21, 16'hffff, 16'h0033);
		rc(8'h39, 16'hffff, 16'h0000);
		chk({8'h00, vid_out}, 16'h0033);
	endtask : t_reboot
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : tally_and_finish
	// hang guard, far beyond the hundred or so cycles used
	always @(posedge clock) begin
		cyc++;
		if (cyc == 2000) begin
			n_fail++;
			tally_and_finish;
		end
	end
	initial begin
		{sys_rst, protocol_strap_pin} = 2'h3;
		{protocol_select_config, protocol_use_config, ov_detect} = 3'h0;
		operation_select = 2'h0;
		boot_voltage = 8'h5a;
		raw_current = 16'h0000;
		repeat (20) @(negedge clock);
		sys_rst = 1'b0;
		repeat (3) @(negedge clock);
		t_reset;
		t_mode;
		t_clamp;
		t_margin;
		t_offset;
		t_refuse;
		t_ov;
		t_store;
		t_reboot;
		tally_and_finish;
	end
endmodule : test_pmbus_output_voltage_target_set
`default_nettype wire
